/* verilog/hpc_host_port.sv */
// Host port cycle decode, control latching, halfword sequencing and ready
`include "hpc_regs.svh"
module hpc_host_port import hpc_pkg::*; #(
    parameter int DATA_W = 32,
    parameter int TMR_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic port_select_n_i,
    input wire logic data_strobe_a_i,
    input wire logic data_strobe_b_i,
    input wire logic address_latch_n_i,
    input wire logic [1:0] access_select_i,
    input wire logic direction_select_i,
    input wire logic halfword_identifier_i,
    input wire logic [DATA_W-1:0] host_data_bus_i,
    output logic [DATA_W-1:0] host_data_bus_o,
    output logic host_data_bus_oe_o,
    output logic ready_n_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    if (DATA_W != 32) begin : g_chk_w
        $error("hpc_host_port: DATA_W must be 32");
    end
    if (`HPC_ADDR_WAIT_CYC >= 2 ** TMR_W) begin : g_chk_t
        $error("hpc_host_port: TMR_W too small");
    end

    function automatic logic [31:0] hpc_bmask(input logic [31:0] o, input logic [31:0] n,
                                              input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction : hpc_bmask

    // Upper half is selected when identifier and order bit differ
    function automatic logic hpc_upper(input logic hw, input logic halfword_order_bit);
        return hw ^ halfword_order_bit;
    endfunction : hpc_upper

    // ----------------------------------------
    // Pin synchronisation and strobes
    // ----------------------------------------
    hpc_pins_t pin_raw;
    hpc_pins_t pin_s;
    logic stb_n_s;
    logic stb_fall;
    logic stb_rise;
    logic as_fall;
    hpc_ctl_t cur;

    assign pin_raw = '{cs_n: port_select_n_i, ds_a: data_strobe_a_i, ds_b: data_strobe_b_i,
                       as_n: address_latch_n_i,
                       ctl: '{sel: access_select_i, dir: direction_select_i, hw: halfword_identifier_i},
                       data: host_data_bus_i};

    hpc_sync #(.W($bits(hpc_pins_t)), .RST_VAL({4'hF, 4'h0, 32'h0000_0000})) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pin_raw),
        .q_o(pin_s)
    );

    // Strobe is active low; XNOR suits either strobe polarity
    assign stb_n_s = ~(pin_s.ds_a ^ pin_s.ds_b) | pin_s.cs_n;

    // ----------------------------------------
    // Host cycle state
    // ----------------------------------------
    hpc_state_t state_q, state_d;
    hpc_wait_t kind_q, kind_d;
    hpc_ctl_t ctl_q, ctl_d;
    hpc_ctl_t cyc_q, cyc_d;
    logic stb_prev_q, stb_prev_d;
    logic as_prev_q, as_prev_d;
    logic as_hold_q, as_hold_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic halfword_order_bit_q, halfword_order_bit_d;
    logic [31:0] wdata_q, wdata_d;
    logic [31:0] dout_q, dout_d;
    logic wpend_q, wpend_d;
    logic ravail_q, ravail_d;
    logic abort_q, abort_d;
    logic first_inc_q, first_inc_d;
    logic mode32_q, mode32_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] addr_r_q;
    logic [31:0] addr_w_q;
    logic a_wr, a_half, a_up, inc_r, inc_w;
    logic first, last, upper, cond_ok;
    logic [15:0] c16;
    logic [31:0] word;
    logic wb_hit, wb_wr, wb_rd;
    logic [31:0] wb_dat_d, cfg_w;

    assign as_fall = as_prev_q & ~pin_s.as_n;
    assign stb_fall = stb_prev_q & ~stb_n_s;
    assign stb_rise = ~stb_prev_q & stb_n_s;
    assign cur = as_hold_q ? ctl_q : pin_s.ctl;
    assign first = mode32_q | ~cur.hw;
    assign last = mode32_q | cyc_q.hw;
    assign upper = hpc_upper(cyc_q.hw, halfword_order_bit_q);
    assign c16 = 16'(halfword_order_bit_q) << `HPC_CTL_HALFWORD_ORDER_BIT | 16'(halfword_order_bit_q) << `HPC_CTL_HALFWORD_ORDER_BIT_MIR;
    assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr = wb_hit & wb_we_i;
    assign wb_rd = wb_hit & ~wb_we_i;

    always_comb begin
        unique case (kind_q)
            HPC_W_ADDR: cond_ok = tmr_q == '0;
            HPC_W_RD: cond_ok = ravail_q;
            default: cond_ok = ~wpend_q;
        endcase
        unique case (cyc_q.sel)
            `HPC_SEL_CTRL: word = mode32_q ? {16'h0000, c16} : {c16, c16};
            `HPC_SEL_ADDR: word = addr_r_q;
            default: word = rdata_q;
        endcase
    end

    always_comb begin
        state_d = state_q;
        kind_d = kind_q;
        ctl_d = ctl_q;
        cyc_d = cyc_q;
        stb_prev_d = stb_n_s;
        as_prev_d = pin_s.as_n;
        as_hold_d = as_hold_q;
        tmr_d = tmr_q;
        halfword_order_bit_d = halfword_order_bit_q;
        wdata_d = wdata_q;
        wpend_d = wpend_q;
        ravail_d = ravail_q;
        abort_d = abort_q;
        first_inc_d = first_inc_q;
        a_wr = 1'b0;
        a_half = ~mode32_q;
        a_up = upper;
        inc_r = 1'b0;
        inc_w = 1'b0;
        // Full word in 32-bit mode, otherwise the selected half on both halves
        dout_d = mode32_q ? word : (upper ? {word[31:16], word[31:16]} : {word[15:0], word[15:0]});
        if (stb_rise) begin
            as_hold_d = 1'b0;
        end
        if (as_fall) begin
            ctl_d = pin_s.ctl;
            as_hold_d = 1'b1;
        end
        unique case (state_q)
            HPC_IDLE: begin
                if (stb_fall) begin
                    cyc_d = cur;
                    state_d = HPC_READY;
                    unique case (cur.sel)
                        `HPC_SEL_ADDR: begin
                            if (!cur.dir) begin
                                state_d = HPC_BUSY;
                                kind_d = HPC_W_ADDR;
                                tmr_d = TMR_W'(`HPC_ADDR_WAIT_CYC);
                            end
                        end
                        `HPC_SEL_DFIX, `HPC_SEL_DINC: begin
                            if (!cur.dir && wpend_q) begin
                                state_d = HPC_BUSY;
                                kind_d = HPC_W_WR;
                            end else if (cur.dir && first &&
                                         (cur.sel == `HPC_SEL_DFIX || first_inc_q)) begin
                                state_d = HPC_BUSY;
                                kind_d = HPC_W_RD;
                                ravail_d = 1'b0;
                            end
                        end
                        default: state_d = HPC_READY;
                    endcase
                end
            end
            HPC_BUSY, HPC_READY: begin
                if (state_q == HPC_BUSY && tmr_q != '0) begin
                    tmr_d = tmr_q - TMR_W'(1);
                end
                if (state_q == HPC_BUSY && cond_ok) begin
                    state_d = HPC_READY;
                end
                if (stb_rise) begin
                    state_d = HPC_IDLE;
                    if (state_q == HPC_BUSY) begin
                        abort_d = 1'b1;
                    end
                    if (!cyc_q.dir) begin
                        unique case (cyc_q.sel)
                            `HPC_SEL_CTRL: halfword_order_bit_d = pin_s.data[`HPC_CTL_HALFWORD_ORDER_BIT];
                            `HPC_SEL_ADDR: begin
                                a_wr = 1'b1;
                                first_inc_d = first_inc_q | last;
                            end
                            default: begin
                                if (mode32_q) begin
                                    wdata_d = pin_s.data;
                                end else if (upper) begin
                                    wdata_d[31:16] = pin_s.data[15:0];
                                end else begin
                                    wdata_d[15:0] = pin_s.data[15:0];
                                end
                                wpend_d = wpend_q | last;
                                inc_w = last && cyc_q.sel == `HPC_SEL_DINC;
                            end
                        endcase
                    end else if (cyc_q.sel[0] && last) begin
                        ravail_d = 1'b0;
                        inc_r = cyc_q.sel == `HPC_SEL_DINC;
                        if (cyc_q.sel == `HPC_SEL_DINC) begin
                            first_inc_d = 1'b0;
                        end
                    end
                end
            end
            default: state_d = HPC_IDLE;
        endcase
        // Software side clears lose to a host set in the same cycle
        if (wb_rd && wb_adr_i == `HPC_WB_WDATA &&
            !(stb_rise && state_q != HPC_IDLE && !cyc_q.dir && cyc_q.sel[0] && last)) begin
            wpend_d = 1'b0;
        end
        if (wb_wr && wb_adr_i == `HPC_WB_STAT && wb_sel_i[0] && wb_dat_i[`HPC_ST_ABORT] &&
            !(stb_rise && state_q == HPC_BUSY)) begin
            abort_d = 1'b0;
        end
        if (wb_wr && wb_adr_i == `HPC_WB_RDATA) begin
            ravail_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= HPC_IDLE;
            kind_q <= HPC_W_ADDR;
            ctl_q <= '0;
            cyc_q <= '0;
            stb_prev_q <= 1'b1;
            as_prev_q <= 1'b1;
            as_hold_q <= 1'b0;
            tmr_q <= '0;
            halfword_order_bit_q <= 1'b0;
            wdata_q <= `HPC_RST_WORD;
            dout_q <= `HPC_RST_WORD;
            wpend_q <= 1'b0;
            ravail_q <= 1'b0;
            abort_q <= 1'b0;
            first_inc_q <= 1'b0;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            ctl_q <= ctl_d;
            cyc_q <= cyc_d;
            stb_prev_q <= stb_prev_d;
            as_prev_q <= as_prev_d;
            as_hold_q <= as_hold_d;
            tmr_q <= tmr_d;
            halfword_order_bit_q <= halfword_order_bit_d;
            wdata_q <= wdata_d;
            dout_q <= dout_d;
            wpend_q <= wpend_d;
            ravail_q <= ravail_d;
            abort_q <= abort_d;
            first_inc_q <= first_inc_d;
        end
    end

    // Single address register mode: an address write loads both
    hpc_addr_reg #(.W(32)) u_addr_r (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(a_wr),
        .half_i(a_half),
        .upper_i(a_up),
        .wd_i(pin_s.data),
        .inc_i(inc_r),
        .q_o(addr_r_q)
    );
    hpc_addr_reg #(.W(32)) u_addr_w (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(a_wr),
        .half_i(a_half),
        .upper_i(a_up),
        .wd_i(pin_s.data),
        .inc_i(inc_w),
        .q_o(addr_w_q)
    );

    assign host_data_bus_o = dout_q;
    assign host_data_bus_oe_o = state_q == HPC_READY && cyc_q.dir;
    // Raw select gates ready so deselect acts without sync delay
    assign ready_n_o = state_q == HPC_BUSY && !port_select_n_i;

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    always_comb begin
        mode32_d = mode32_q;
        rdata_d = rdata_q;
        wb_dat_d = wb_dat_o;
        cfg_w = hpc_bmask(32'(mode32_q) << `HPC_CFG_MODE32, wb_dat_i, wb_sel_i);
        if (wb_wr && wb_adr_i == `HPC_WB_CFG) begin
            mode32_d = cfg_w[`HPC_CFG_MODE32];
        end
        if (wb_wr && wb_adr_i == `HPC_WB_RDATA) begin
            rdata_d = hpc_bmask(rdata_q, wb_dat_i, wb_sel_i);
        end
        if (wb_rd) begin
            unique case (wb_adr_i)
                `HPC_WB_CFG: wb_dat_d = 32'(mode32_q) << `HPC_CFG_MODE32;
                `HPC_WB_STAT: wb_dat_d = 32'(wpend_q) << `HPC_ST_WPEND | 32'(ravail_q) << `HPC_ST_RAVAIL
                    | 32'(abort_q) << `HPC_ST_ABORT | 32'(state_q == HPC_BUSY && kind_q == HPC_W_RD)
                    << `HPC_ST_RWAIT | 32'(halfword_order_bit_q) << `HPC_ST_HALFWORD_ORDER_BIT;
                `HPC_WB_ADDRR: wb_dat_d = addr_r_q;
                `HPC_WB_ADDRW: wb_dat_d = addr_w_q;
                `HPC_WB_WDATA: wb_dat_d = wdata_q;
                `HPC_WB_RDATA: wb_dat_d = rdata_q;
                default: wb_dat_d = `HPC_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `HPC_RST_WORD;
            mode32_q <= 1'b0;
            rdata_q <= `HPC_RST_WORD;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= wb_dat_d;
            mode32_q <= mode32_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_ready_gated: assert property (port_select_n_i |-> !ready_n_o)
        else $error("ready shown not-ready while deselected");
    chk_ctrl_nowait: assert property (stb_fall && state_q == HPC_IDLE && cur.sel == `HPC_SEL_CTRL
        |=> state_q == HPC_READY) else $error("control access waited");
    chk_addr_wait: assert property (stb_fall && state_q == HPC_IDLE && cur.sel == `HPC_SEL_ADDR
        && !cur.dir && !stb_n_s ##1 !stb_n_s [*5] |=> state_q == HPC_READY)
        else $error("address write wait wrong");
    chk_fix_second: assert property (stb_fall && state_q == HPC_IDLE && cur.sel == `HPC_SEL_DFIX
        && cur.dir && !mode32_q && cur.hw |=> state_q == HPC_READY) else $error("second half waited");
    chk_abort_flag: assert property (stb_rise && state_q == HPC_BUSY |=> abort_q)
        else $error("early strobe not flagged");
    chk_halfword_order_bit_write: assert property (stb_rise && state_q == HPC_READY && !cyc_q.dir
        && cyc_q.sel == `HPC_SEL_CTRL |=> c16[8] == $past(pin_s.data[0])) else $error("order bit lost");
    chk_inc_write: assert property (stb_rise && state_q == HPC_READY && !cyc_q.dir
        && cyc_q.sel == `HPC_SEL_DINC && last |=> addr_w_q == $past(addr_w_q) + 32'h0000_0001)
        else $error("write address not incremented");
    chk_word_write: assert property (stb_rise && state_q == HPC_READY && !cyc_q.dir && mode32_q
        && cyc_q.sel[0] |=> wpend_q && wdata_q == $past(pin_s.data)) else $error("word not captured");
    chk_as_latch: assert property (as_fall |=> ctl_q == $past(pin_s.ctl))
        else $error("latch strobe capture wrong");
    chk_unsel_idle: assert property (pin_s.cs_n && state_q == HPC_IDLE |=> state_q == HPC_IDLE)
        else $error("cycle started while deselected");

    cov_abort: cover property (stb_rise && state_q == HPC_BUSY);
    cov_inc_read: cover property (stb_rise && cyc_q.sel == `HPC_SEL_DINC && cyc_q.dir && last);
    cov_addr_wait: cover property (state_q == HPC_BUSY && kind_q == HPC_W_ADDR ##1 state_q == HPC_READY);
endmodule : hpc_host_port

/* verilog/hpc_regs.svh */
// Constants of the host port cycle block: offsets, fields, codes, timing
`ifndef HPC_REGS_SVH
`define HPC_REGS_SVH
// ----------------------------------------
// Access select codes
// ----------------------------------------
`define HPC_SEL_CTRL 2'h0
`define HPC_SEL_DINC 2'h1
`define HPC_SEL_ADDR 2'h2
`define HPC_SEL_DFIX 2'h3
// ----------------------------------------
// Port control register fields
// ----------------------------------------
`define HPC_CTL_HALFWORD_ORDER_BIT 0
`define HPC_CTL_HALFWORD_ORDER_BIT_MIR 8
// ----------------------------------------
// Wishbone register offsets and fields
// ----------------------------------------
`define HPC_WB_CFG 8'h00
`define HPC_WB_STAT 8'h04
`define HPC_WB_ADDRR 8'h08
`define HPC_WB_ADDRW 8'h0C
`define HPC_WB_WDATA 8'h10
`define HPC_WB_RDATA 8'h14
`define HPC_CFG_MODE32 0
`define HPC_ST_WPEND 0
`define HPC_ST_RAVAIL 1
`define HPC_ST_ABORT 2
`define HPC_ST_RWAIT 3
`define HPC_ST_HALFWORD_ORDER_BIT 4
`define HPC_RST_WORD 32'h0000_0000
// ----------------------------------------
// Timing
// ----------------------------------------
`define HPC_CLK_NS 10
`define HPC_ADDR_WAIT_NS 40
`define HPC_ADDR_WAIT_CYC ((`HPC_ADDR_WAIT_NS + `HPC_CLK_NS - 1) / `HPC_CLK_NS)
`endif

/* verilog/hpc_pkg.sv */
// Types shared by the host port cycle block
package hpc_pkg;
    typedef enum logic [1:0] {
        HPC_IDLE = 2'b00,
        HPC_BUSY = 2'b01,
        HPC_READY = 2'b10
    } hpc_state_t;

    typedef enum logic [1:0] {
        HPC_W_ADDR = 2'b00,
        HPC_W_RD = 2'b01,
        HPC_W_WR = 2'b10
    } hpc_wait_t;

    typedef struct packed {
        logic [1:0] sel;
        logic dir;
        logic hw;
    } hpc_ctl_t;

    typedef struct packed {
        logic cs_n;
        logic ds_a;
        logic ds_b;
        logic as_n;
        hpc_ctl_t ctl;
        logic [31:0] data;
    } hpc_pins_t;
endpackage : hpc_pkg

/* verilog/hpc_sync.sv */
// Two-flop synchroniser for a bundle of host pins
module hpc_sync #(
    parameter int W = 40,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s1_d;
    logic [W-1:0] s2_d;

    always_comb begin
        s1_d = rst_i ? RST_VAL : d_i;
        s2_d = rst_i ? RST_VAL : s1_q;
    end

    always_ff @(posedge clk_i) begin
        s1_q <= s1_d;
        q_o <= s2_d;
    end
endmodule : hpc_sync

/* verilog/hpc_addr_reg.sv */
// Halfword-loadable address register with post-increment
module hpc_addr_reg #(
    parameter int W = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic half_i,
    input wire logic upper_i,
    input wire logic [W-1:0] wd_i,
    input wire logic inc_i,
    output logic [W-1:0] q_o
);
    localparam int H = W / 2;
    logic [W-1:0] q_d;

    if (W % 2 != 0 || W < 2) begin : g_chk
        $error("hpc_addr_reg: W must be even");
    end

    always_comb begin
        q_d = q_o;
        if (wr_i && !half_i) begin
            q_d = wd_i;
        end else if (wr_i && upper_i) begin
            q_d[W-1:H] = wd_i[H-1:0];
        end else if (wr_i) begin
            q_d[H-1:0] = wd_i[H-1:0];
        end else if (inc_i) begin
            q_d = q_o + W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= '0;
        end else begin
            q_o <= q_d;
        end
    end
endmodule : hpc_addr_reg

/* bench/hpc_host_model.sv */
// Host processor model driving the multiplexed host port pins
module hpc_host_model (
    input wire logic clk_i,
    input wire logic ready_n_i,
    input wire logic oe_i,
    input wire logic [31:0] hd_i,
    output logic cs_n_o = 1'b1,
    output logic ds_a_o = 1'b0,
    output logic ds_b_o = 1'b0,
    output logic as_n_o = 1'b1,
    output logic [1:0] sel_o = 2'h0,
    output logic dir_o = 1'b0,
    output logic hw_o = 1'b0,
    output logic [31:0] hd_o = 32'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // One transfer; single active-high strobe, the other idles low
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic xfer(input logic [1:0] s, input logic d, input logic h, input logic a, input logic e,
                        input logic [31:0] wd, output logic [31:0] rd, output logic wt);
        int n;
        wt = 1'b0;
        sel_o <= s;
        dir_o <= d;
        hw_o <= h;
        cs_n_o <= 1'b0;
        // Released bus must never echo the last value
        hd_o <= d ? ~hd_o : wd;
        tick(3);
        if (a) begin
            as_n_o <= 1'b0;
            tick(3);
            // Lines move after the latch so only a real capture passes
            sel_o <= ~s;
            dir_o <= ~d;
            hw_o <= ~h;
        end
        ds_a_o <= 1'b1;
        // Early release when a scenario commands it, or after 300 cycles without ready
        for (n = 0; n < 300 && !(n > 5 && (e || ready_n_i === 1'b0)); n++) begin
            @(posedge clk_i);
            if (ready_n_i === 1'b1) wt = 1'b1;
        end
        // Undriven bus reads as zero
        rd = hd_i & {32{oe_i}};
        ds_a_o <= 1'b0;
        tick(3);
        as_n_o <= 1'b1;
        cs_n_o <= 1'b1;
        tick(3);
    endtask : xfer
endmodule : hpc_host_model

/* bench/testbench.sv */
// Self-checking bench for the host port cycle block
`include "hpc_regs.svh"
`define CHECK(nm, ex, got) begin \
    tests_run++; \
    if ((got) !== (ex)) begin \
        err_count++; \
        $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] CT = `HPC_SEL_CTRL, DI = `HPC_SEL_DINC, AD = `HPC_SEL_ADDR, DF = `HPC_SEL_DFIX;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0, wsel = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, q, rd;
    logic wt;
    wire [31:0] wb_dat_o, host_data_bus_i, host_data_bus_o;
    wire [1:0] access_select_i;
    wire wb_ack_o, ready_n_o, port_select_n_i, data_strobe_a_i, data_strobe_b_i, address_latch_n_i;
    wire direction_select_i, halfword_identifier_i, oe;
    int err_count = 0, tests_run = 0;
    always #5 clk_i = ~clk_i;
    hpc_host_port i_dut (.clk_i, .rst_i, .port_select_n_i, .data_strobe_a_i, .data_strobe_b_i, .address_latch_n_i,
        .access_select_i, .direction_select_i, .halfword_identifier_i, .host_data_bus_i, .host_data_bus_o,
        .host_data_bus_oe_o(oe), .ready_n_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o);
    hpc_host_model i_host (.clk_i, .ready_n_i(ready_n_o), .oe_i(oe), .hd_i(host_data_bus_o),
        .cs_n_o(port_select_n_i), .ds_a_o(data_strobe_a_i), .ds_b_o(data_strobe_b_i), .as_n_o(address_latch_n_i),
        .sel_o(access_select_i), .dir_o(direction_select_i), .hw_o(halfword_identifier_i), .hd_o(host_data_bus_i));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= wsel;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        // Only the watchdog ends a wait for ack
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic wbr(input logic [7:0] adr, input logic [31:0] ex);
        wb(1'b0, adr, 32'h0);
        `CHECK("wb read", ex, q)
    endtask : wbr
    task automatic hx(input logic [1:0] s, input logic d, input logic h, input logic a, input logic [31:0] wd,
                      input logic [31:0] ex, input logic ew);
        i_host.xfer(s, d, h, a, 1'b0, wd, rd, wt);
        `CHECK("host wait", ew, wt)
        if (d) `CHECK("host read", ex, rd)
    endtask : hx
    task automatic end_of_test();
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test
    // Deselected port must never show wait
    always @(posedge clk_i) begin
        if (!rst_i && port_select_n_i === 1'b1) `CHECK("ready deselected", 1'b0, ready_n_o)
    end
    initial begin
        #300000;
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wbr(`HPC_WB_CFG, 32'h0);
        wbr(8'h40, 32'h0);
        hx(CT, 1'b0, 1'b0, 1'b0, 32'h0000_0001, 32'h0, 1'b0);
        hx(CT, 1'b1, 1'b0, 1'b0, 32'h0, 32'h0101_0101, 1'b0);
        hx(CT, 1'b1, 1'b1, 1'b0, 32'h0, 32'h0101_0101, 1'b0);
        hx(AD, 1'b0, 1'b0, 1'b0, 32'h0000_1234, 32'h0, 1'b1);
        hx(AD, 1'b0, 1'b1, 1'b0, 32'h0000_5678, 32'h0, 1'b1);
        wbr(`HPC_WB_ADDRW, 32'h1234_5678);
        hx(AD, 1'b1, 1'b0, 1'b0, 32'h0, 32'h1234_1234, 1'b0);
        fork
            hx(DI, 1'b1, 1'b0, 1'b0, 32'h0, 32'hCAFE_CAFE, 1'b1);
            begin
                repeat (20) @(posedge clk_i);
                wb(1'b1, `HPC_WB_RDATA, 32'hCAFE_BEEF);
            end
        join
        hx(DI, 1'b1, 1'b1, 1'b0, 32'h0, 32'hBEEF_BEEF, 1'b0);
        wbr(`HPC_WB_ADDRR, 32'h1234_5679);
        i_host.xfer(DI, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0, rd, wt);
        `CHECK("host wait", 1'b0, wt)
        fork
            hx(DF, 1'b1, 1'b0, 1'b0, 32'h0, 32'h2222_2222, 1'b1);
            begin
                repeat (20) @(posedge clk_i);
                wb(1'b1, `HPC_WB_RDATA, 32'h2222_1111);
            end
        join
        hx(DF, 1'b1, 1'b1, 1'b0, 32'h0, 32'h1111_1111, 1'b0);
        hx(DF, 1'b0, 1'b0, 1'b0, 32'h0000_ABCD, 32'h0, 1'b0);
        hx(DF, 1'b0, 1'b1, 1'b0, 32'h0000_0123, 32'h0, 1'b0);
        wb(1'b0, `HPC_WB_STAT, 32'h0);
        `CHECK("write pending", 1'b1, q[`HPC_ST_WPEND])
        wbr(`HPC_WB_WDATA, 32'hABCD_0123);
        wb(1'b1, `HPC_WB_CFG, 32'h0000_0001);
        // Byte lane 0 off: mode bit must survive
        wsel = 4'hE;
        wb(1'b1, `HPC_WB_CFG, 32'h0000_0000);
        wsel = 4'hF;
        wbr(`HPC_WB_CFG, 32'h0000_0001);
        hx(CT, 1'b1, 1'b1, 1'b0, 32'h0, 32'h0000_0101, 1'b0);
        hx(AD, 1'b0, 1'b1, 1'b1, 32'hA5A5_0F0F, 32'h0, 1'b1);
        wbr(`HPC_WB_ADDRW, 32'hA5A5_0F0F);
        i_host.xfer(DF, 1'b1, 1'b0, 1'b0, 1'b1, 32'h0, rd, wt);
        wb(1'b0, `HPC_WB_STAT, 32'h0);
        `CHECK("abort flag", 1'b1, q[`HPC_ST_ABORT])
        wb(1'b1, `HPC_WB_STAT, 32'h0000_0004);
        i_host.ds_a_o <= 1'b1;
        repeat (8) @(posedge clk_i);
        i_host.ds_a_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        wbr(`HPC_WB_STAT, 32'h0000_0010);
        hx(DI, 1'b0, 1'b0, 1'b0, 32'h1111_2222, 32'h0, 1'b0);
        wbr(`HPC_WB_ADDRW, 32'hA5A5_0F10);
        wbr(`HPC_WB_WDATA, 32'h1111_2222);
        end_of_test();
    end
endmodule : testbench
